//--- hdl/crsie_pkg.sv
/*
 * Package of the CPU register set and interrupt entry block: register
 * indices, reset values, stack and vector constants, command and state types.
 * Assumes a single clock domain shared by sequencer, memory and block.
 */
package crsie_pkg;

  // ****************************************************************
  // Constants
  // ****************************************************************
  localparam int unsigned SP_LOW_W     = 6;               // Writable stack bits
  localparam int unsigned PC_W         = 11;              // Live fetch bits
  localparam logic [15:0] STACK_RESET  = 16'h00ff;
  localparam logic [9:0]  STACK_UPPER  = 10'h003;         // Fixed 0000000011
  localparam logic [4:0]  PC_UPPER     = 5'h00;
  localparam logic [2:0]  FLAGS_UPPER  = 3'h7;
  localparam logic [15:0] VEC_SOFT     = 16'h07fc;
  localparam logic [15:0] VEC_EXT      = 16'h07fa;
  localparam logic [15:0] VEC_TIMER    = 16'h07f8;
  localparam logic [2:0]  PUSH_CALL    = 3'h2;
  localparam logic [2:0]  PUSH_TRAP    = 3'h5;
  localparam logic [3:0]  PULL_CALL    = 4'h1;            // Last index, pch..pcl
  localparam logic [3:0]  PULL_TRAP    = 4'h4;            // Last index, flags..pcl
  localparam int unsigned MUL_CYCLES   = 11;
  localparam logic [3:0]  MUL_LAST     = 4'(MUL_CYCLES - 1);
  localparam logic [3:0]  MUL_STEPS    = 4'h8;
  localparam logic        EXT_EN_RESET = 1'b1;

  // Register indices on the plain register port
  localparam logic [2:0] REG_WORK   = 3'h0;
  localparam logic [2:0] REG_PTR    = 3'h1;
  localparam logic [2:0] REG_STACK  = 3'h2;
  localparam logic [2:0] REG_FETCH  = 3'h3;
  localparam logic [2:0] REG_FLAGS  = 3'h4;
  localparam logic [2:0] REG_CTRL   = 3'h5;
  localparam logic [2:0] REG_STATUS = 3'h6;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [4:0] {
    OP_NOP, OP_LOAD_WORK, OP_LOAD_PTR, OP_ADD, OP_ADC, OP_SUB, OP_SBC,
    OP_AND, OP_OR, OP_XOR, OP_MUL, OP_STACK_REINIT, OP_UNMASK, OP_STOP,
    OP_WAIT, OP_JUMP, OP_CALL, OP_RETURN, OP_SOFT_TRAP, OP_RETURN_TRAP
  } crsie_op_type;

  typedef enum logic [2:0] {PH_IDLE, PH_MUL, PH_PUSH, PH_VEC, PH_PULL} crsie_phase_type;

  typedef struct packed {
    crsie_op_type op;
    logic [15:0]  operand;   // Data byte in [7:0] or target address
    logic         adv;       // Fetch took place: step the fetch pointer
    logic         last;      // Final step of the instruction
  } crsie_cmd_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } crsie_mem_req_type;

  typedef struct packed {
    crsie_phase_type phase;
    logic [3:0]      cnt;
    logic            half;
    logic [2:0]      push_n;
    logic [15:0]     vec;
    logic            boundary;
    logic [7:0]      work;
    logic [7:0]      ptr;
    logic [5:0]      sp;
    logic [10:0]     pc;
    logic            h, i, n, z, c;
    logic            ext_en;
    logic [15:0]     mul_acc;
    logic [15:0]     rd_data;
  } crsie_state_type;

endpackage

//--- hdl/crsie_core.sv
/*
 * CPU programming model: work and pointer bytes, stack top, fetch pointer,
 * condition flags, ALU with multiply, and interrupt entry and return.
 * Assumes the sequencer, memory and interrupt latches share clk; memory
 * read data arrive the cycle after a read request.
 */
`timescale 1ns/1ps

module crsie_core (
  input  wire logic                        clk,
  input  wire logic                        nrst,
  input  wire logic                        ce,
  input  wire crsie_pkg::crsie_cmd_type    cmd,
  input  wire logic                        cmd_valid,
  output logic                             cmd_ready,
  output crsie_pkg::crsie_mem_req_type     mem_req,
  input  wire logic [7:0]                  mem_rdata,
  input  wire logic                        ext_req_pend,
  input  wire logic                        timer_req,
  output logic                             ext_ack,
  output logic                             timer_ack,
  input  wire logic [2:0]                  reg_addr,
  input  wire logic [15:0]                 reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic [15:0]                      reg_rdata
);

  // ****************************************************************
  // State and views
  // ****************************************************************
  crsie_pkg::crsie_state_type s_q;
  crsie_pkg::crsie_state_type s_d;
  logic [15:0] stack_top;
  logic [15:0] fetch_pointer;
  logic [7:0]  cond_flags;
  logic        ext_ok;
  logic        timer_ok;
  logic        take_irq;
  logic        is_sub;
  logic        cin;
  logic [7:0]  b_eff;
  logic [8:0]  sum9;
  logic [4:0]  sum5;
  logic [8:0]  mul_sum;
  logic [7:0]  lres;

  // Fixed upper bits are wired, never stored
  assign stack_top     = {crsie_pkg::STACK_UPPER, s_q.sp};
  assign fetch_pointer = {crsie_pkg::PC_UPPER, s_q.pc};
  assign cond_flags    = {crsie_pkg::FLAGS_UPPER, s_q.h, s_q.i, s_q.n, s_q.z, s_q.c};

  // Byte pushed at stack index k
  function automatic logic [7:0] stack_byte(input crsie_pkg::crsie_state_type s,
                                            input logic [3:0] k);
    logic [7:0] b;
    b = 8'h00;
    unique case (k)
      4'h0:    b = s.pc[7:0];
      4'h1:    b = {5'h00, s.pc[10:8]};
      4'h2:    b = s.ptr;
      4'h3:    b = s.work;
      default: b = {crsie_pkg::FLAGS_UPPER, s.h, s.i, s.n, s.z, s.c};
    endcase
    return b;
  endfunction

  // ****************************************************************
  // Interrupt arbitration
  // ****************************************************************
  // Requests only at an instruction boundary; external outranks timer
  assign ext_ok    = ext_req_pend && s_q.ext_en && !s_q.i;
  assign timer_ok  = timer_req && !s_q.i;
  assign take_irq  = (s_q.phase == crsie_pkg::PH_IDLE) && s_q.boundary
                     && (ext_ok || timer_ok);
  assign cmd_ready = (s_q.phase == crsie_pkg::PH_IDLE) && !take_irq;

  // ****************************************************************
  // Adder path
  // ****************************************************************
  // Subtraction goes through the same adder with the operand inverted
  always_comb begin
    is_sub = (cmd.op == crsie_pkg::OP_SUB) || (cmd.op == crsie_pkg::OP_SBC);
    b_eff  = is_sub ? ~cmd.operand[7:0] : cmd.operand[7:0];
    unique case (cmd.op)
      crsie_pkg::OP_ADC: cin = s_q.c;
      crsie_pkg::OP_SUB: cin = 1'b1;
      crsie_pkg::OP_SBC: cin = ~s_q.c;
      default:           cin = 1'b0;
    endcase
    sum9 = {1'b0, s_q.work} + {1'b0, b_eff} + {8'h00, cin};
    sum5 = {1'b0, s_q.work[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
    mul_sum = {1'b0, s_q.mul_acc[15:8]} + (s_q.mul_acc[0] ? {1'b0, s_q.ptr} : 9'h000);
    lres = (cmd.op == crsie_pkg::OP_AND) ? s_q.work & cmd.operand[7:0]
         : (cmd.op == crsie_pkg::OP_OR)  ? s_q.work | cmd.operand[7:0]
         : (cmd.op == crsie_pkg::OP_XOR) ? s_q.work ^ cmd.operand[7:0] : cmd.operand[7:0];
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d         = s_q;
    s_d.rd_data = 16'h0000;
    mem_req     = '0;
    ext_ack     = 1'b0;
    timer_ack   = 1'b0;
    unique case (s_q.phase)
      crsie_pkg::PH_IDLE: begin
        if (take_irq) begin
          s_d.phase    = crsie_pkg::PH_PUSH;
          s_d.push_n   = crsie_pkg::PUSH_TRAP;
          s_d.cnt      = 4'h0;
          s_d.boundary = 1'b0;
          s_d.vec      = ext_ok ? crsie_pkg::VEC_EXT : crsie_pkg::VEC_TIMER;
        end else if (cmd_valid) begin
          s_d.boundary = cmd.last;
          if (cmd.adv) begin
            s_d.pc = s_q.pc + 11'h001;
          end
          unique case (cmd.op)
            crsie_pkg::OP_LOAD_WORK, crsie_pkg::OP_AND, crsie_pkg::OP_OR,
            crsie_pkg::OP_XOR, crsie_pkg::OP_LOAD_PTR: begin
              if (cmd.op == crsie_pkg::OP_LOAD_PTR) begin
                s_d.ptr = lres;
              end else begin
                s_d.work = lres;
              end
              s_d.n = lres[7];
              s_d.z = (lres == 8'h00);
            end
            crsie_pkg::OP_ADD, crsie_pkg::OP_ADC, crsie_pkg::OP_SUB,
            crsie_pkg::OP_SBC: begin
              s_d.work = sum9[7:0];
              s_d.n    = sum9[7];
              s_d.z    = (sum9[7:0] == 8'h00);
              s_d.c    = is_sub ? ~sum9[8] : sum9[8];
              if (!is_sub) begin
                s_d.h = sum5[4];
              end
            end
            crsie_pkg::OP_MUL: begin
              s_d.phase   = crsie_pkg::PH_MUL;
              s_d.cnt     = 4'h1;
              s_d.mul_acc = {8'h00, s_q.work};
            end
            crsie_pkg::OP_STACK_REINIT: s_d.sp = crsie_pkg::STACK_RESET[5:0];
            crsie_pkg::OP_UNMASK, crsie_pkg::OP_STOP,
            crsie_pkg::OP_WAIT: s_d.i = 1'b0;
            crsie_pkg::OP_JUMP: s_d.pc = cmd.operand[10:0];
            crsie_pkg::OP_CALL: begin
              s_d.phase  = crsie_pkg::PH_PUSH;
              s_d.push_n = crsie_pkg::PUSH_CALL;
              s_d.cnt    = 4'h0;
              s_d.vec    = cmd.operand;
            end
            crsie_pkg::OP_RETURN, crsie_pkg::OP_RETURN_TRAP: begin
              s_d.phase = crsie_pkg::PH_PULL;
              s_d.half  = 1'b0;
              s_d.cnt   = (cmd.op == crsie_pkg::OP_RETURN) ? crsie_pkg::PULL_CALL
                                                           : crsie_pkg::PULL_TRAP;
            end
            crsie_pkg::OP_SOFT_TRAP: begin
              s_d.phase    = crsie_pkg::PH_PUSH;
              s_d.push_n   = crsie_pkg::PUSH_TRAP;
              s_d.cnt      = 4'h0;
              s_d.boundary = 1'b0;
              s_d.vec      = crsie_pkg::VEC_SOFT;
            end
            default: ;
          endcase
        end
      end
      // Eight add-shift steps, then idle steps to fill the documented span
      crsie_pkg::PH_MUL: begin
        if (s_q.cnt <= crsie_pkg::MUL_STEPS) begin
          s_d.mul_acc = {mul_sum, s_q.mul_acc[7:1]};
        end
        s_d.cnt = s_q.cnt + 4'h1;
        if (s_q.cnt == crsie_pkg::MUL_LAST) begin
          s_d.phase = crsie_pkg::PH_IDLE;
          s_d.ptr   = s_q.mul_acc[15:8];
          s_d.work  = s_q.mul_acc[7:0];
          s_d.h     = 1'b0;
          s_d.c     = 1'b0;
        end
      end
      // Write at the free slot, then step down; six bits wrap in place
      crsie_pkg::PH_PUSH: begin
        mem_req.wr    = 1'b1;
        mem_req.addr  = stack_top;
        mem_req.wdata = stack_byte(s_q, s_q.cnt);
        s_d.sp        = s_q.sp - 6'h01;
        s_d.cnt       = s_q.cnt + 4'h1;
        if (s_q.cnt == {1'b0, s_q.push_n - 3'h1}) begin
          if (s_q.push_n == crsie_pkg::PUSH_TRAP) begin
            s_d.i     = 1'b1;
            s_d.phase = crsie_pkg::PH_VEC;
            s_d.cnt   = 4'h1;
            s_d.half  = 1'b0;
          end else begin
            s_d.pc    = s_q.vec[10:0];
            s_d.phase = crsie_pkg::PH_IDLE;
          end
        end
      end
      // High byte first, then low; the latch clear rides on the first read
      crsie_pkg::PH_VEC: begin
        s_d.half = ~s_q.half;
        if (!s_q.half) begin
          mem_req.rd   = 1'b1;
          mem_req.addr = s_q.vec + {15'h0000, ~s_q.cnt[0]};
          ext_ack      = s_q.cnt[0] && (s_q.vec == crsie_pkg::VEC_EXT);
          timer_ack    = s_q.cnt[0] && (s_q.vec == crsie_pkg::VEC_TIMER);
        end else if (s_q.cnt[0]) begin
          s_d.pc[10:8] = mem_rdata[2:0];
          s_d.cnt      = 4'h0;
        end else begin
          s_d.pc[7:0]  = mem_rdata;
          s_d.phase    = crsie_pkg::PH_IDLE;
        end
      end
      // Step up before each read, capture a cycle later
      crsie_pkg::PH_PULL: begin
        s_d.half = ~s_q.half;
        if (!s_q.half) begin
          mem_req.rd   = 1'b1;
          mem_req.addr = {crsie_pkg::STACK_UPPER, s_q.sp + 6'h01};
          s_d.sp       = s_q.sp + 6'h01;
        end else begin
          unique case (s_q.cnt)
            4'h0:    s_d.pc[7:0]  = mem_rdata;
            4'h1:    s_d.pc[10:8] = mem_rdata[2:0];
            4'h2:    s_d.ptr      = mem_rdata;
            4'h3:    s_d.work     = mem_rdata;
            default: {s_d.h, s_d.i, s_d.n, s_d.z, s_d.c} = mem_rdata[4:0];
          endcase
          s_d.cnt = s_q.cnt - 4'h1;
          if (s_q.cnt == 4'h0) begin
            s_d.phase = crsie_pkg::PH_IDLE;
          end
        end
      end
      default: s_d.phase = crsie_pkg::PH_IDLE;
    endcase

    // Register port writes take priority over the sequencer
    if (reg_wr) begin
      unique case (reg_addr)
        crsie_pkg::REG_WORK:  s_d.work = reg_wdata[7:0];
        crsie_pkg::REG_PTR:   s_d.ptr  = reg_wdata[7:0];
        crsie_pkg::REG_STACK: s_d.sp   = reg_wdata[5:0];
        crsie_pkg::REG_FETCH: s_d.pc   = reg_wdata[10:0];
        crsie_pkg::REG_FLAGS: {s_d.h, s_d.i, s_d.n, s_d.z, s_d.c} = reg_wdata[4:0];
        crsie_pkg::REG_CTRL:  s_d.ext_en = reg_wdata[0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        crsie_pkg::REG_WORK:   s_d.rd_data = {8'h00, s_q.work};
        crsie_pkg::REG_PTR:    s_d.rd_data = {8'h00, s_q.ptr};
        crsie_pkg::REG_STACK:  s_d.rd_data = stack_top;
        crsie_pkg::REG_FETCH:  s_d.rd_data = fetch_pointer;
        crsie_pkg::REG_FLAGS:  s_d.rd_data = {8'h00, cond_flags};
        crsie_pkg::REG_CTRL:   s_d.rd_data = {15'h0000, s_q.ext_en};
        crsie_pkg::REG_STATUS: s_d.rd_data = {12'h000, s_q.i, timer_req, ext_req_pend,
                                              s_q.phase != crsie_pkg::PH_IDLE};
        default:               s_d.rd_data = 16'h0000;
      endcase
    end

    // Reset leaves the result flags untouched
    if (!nrst) begin
      s_d.phase    = crsie_pkg::PH_IDLE;
      s_d.cnt      = 4'h0;
      s_d.half     = 1'b0;
      s_d.push_n   = 3'h0;
      s_d.vec      = 16'h0000;
      s_d.boundary = 1'b0;
      s_d.work     = 8'h00;
      s_d.ptr      = 8'h00;
      s_d.sp       = crsie_pkg::STACK_RESET[5:0];
      s_d.pc       = 11'h000;
      s_d.i        = 1'b1;
      s_d.ext_en   = crsie_pkg::EXT_EN_RESET;
      s_d.mul_acc  = 16'h0000;
      s_d.rd_data  = 16'h0000;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Reset acts even while the enable is low
  always_ff @(posedge clk) begin
    if (ce || !nrst) begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rd_data;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_stack_reset: assert property (@(posedge clk) !nrst |=> stack_top == 16'h00ff)
    else $error("stack top not 00ff after reset");
  chk_mask_reset: assert property (@(posedge clk) !nrst |=> s_q.i)
    else $error("mask clear after reset");
  chk_stack_span: assert property (@(posedge clk) disable iff (!nrst)
      stack_top >= 16'h00c0 && stack_top <= 16'h00ff)
    else $error("stack top outside its window");
  chk_fetch_upper: assert property (@(posedge clk) disable iff (!nrst)
      fetch_pointer[15:11] == 5'h00 && reg_rdata[15:11] == 5'h00)
    else $error("fetch pointer upper bits set");
  chk_flags_top: assert property (@(posedge clk) disable iff (!nrst)
      s_q.rd_data == 16'h0000 || $past(reg_addr) != crsie_pkg::REG_FLAGS
      || reg_rdata[7:5] == 3'h7)
    else $error("flags upper bits not 111");
  chk_push_step: assert property (@(posedge clk) disable iff (!nrst)
      mem_req.wr && ce && !reg_wr |=> s_q.sp == $past(s_q.sp) - 6'h01)
    else $error("stack top did not step down after push");
  chk_push_order: assert property (@(posedge clk) disable iff (!nrst)
      mem_req.wr && s_q.cnt == 4'h4 |-> mem_req.wdata == cond_flags)
    else $error("flags not the fifth stacked byte");
  chk_mask_before: assert property (@(posedge clk) disable iff (!nrst)
      s_q.phase == crsie_pkg::PH_VEC && mem_req.rd |-> s_q.i)
    else $error("vector fetched with mask clear");
  chk_ext_block: assert property (@(posedge clk) disable iff (!nrst)
      take_irq && !timer_req |-> s_q.ext_en && !s_q.i)
    else $error("blocked external request taken");
  chk_no_abort: assert property (@(posedge clk) disable iff (!nrst)
      take_irq |-> s_q.boundary && !cmd_ready)
    else $error("interrupt taken mid instruction");
  chk_mul_span: assert property (@(posedge clk) disable iff (!nrst)
      s_q.phase == crsie_pkg::PH_MUL && s_d.phase == crsie_pkg::PH_IDLE
      |-> s_q.cnt == 4'ha)
    else $error("multiply length wrong");
  chk_trap_len: assert property (@(posedge clk) disable iff (!nrst)
      ce && cmd_ready && cmd_valid && cmd.op == crsie_pkg::OP_SOFT_TRAP && !reg_wr
      |=> ce[*5] ##1 (stack_top == $past(stack_top, 6) - 16'h0005))
    else $error("trap did not stack five bytes");

  cov_multiply: cover property (@(posedge clk) s_q.phase == crsie_pkg::PH_MUL);
  cov_ext_entry: cover property (@(posedge clk) ext_ack);
  cov_soft_trap: cover property (@(posedge clk)
    cmd_valid && cmd_ready && cmd.op == crsie_pkg::OP_SOFT_TRAP);
  cov_trap_return: cover property (@(posedge clk)
    s_q.phase == crsie_pkg::PH_PULL && s_q.cnt == 4'h4 && s_q.half);

endmodule

//--- verif/crsie_mem.sv
/* Memory model: vectors and stack RAM behind the core.
   Assumes one clock; read data come the cycle after a read request. */
`timescale 1ns/1ps
module crsie_mem (
  input  wire logic                         clk,
  input  wire crsie_pkg::crsie_mem_req_type req,
  output logic [7:0]                        rdata
);
  logic [7:0] mem [0:2047];
  // *****
  // Vector pairs, high byte at the lower address
  // *****
  initial begin
    rdata = 8'h00;
    mem[11'h7fc] = 8'h01;
    mem[11'h7fd] = 8'h23;
    mem[11'h7fa] = 8'h02;
    mem[11'h7fb] = 8'h45;
    mem[11'h7f8] = 8'h03;
    mem[11'h7f9] = 8'h67;
  end
  // Idle cycles show the inverse, so stale data never pass for a read
  always @(posedge clk) begin
    if (req.wr) mem[req.addr[10:0]] <= req.wdata;
    rdata <= req.rd ? mem[req.addr[10:0]] : ~rdata;
  end
endmodule

//--- verif/tb_top.sv
/* Self-checking bench of crsie_core with a memory model.
   Assumes the register index map and timing of the core's package. */
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0, nrst = 1'b0, cmd_valid = 1'b0, ext_pend = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, cr, eack, tack;
  logic ce = 1'b1, tmr = 1'b0, ext_set = 1'b0, tmr_set = 1'b0, cy = 1'b0;
  crsie_pkg::crsie_cmd_type     cmd = '0;
  crsie_pkg::crsie_mem_req_type mreq;
  logic [2:0]  ra = 3'h0;
  logic [15:0] rw = 16'h0, rd, v;
  logic [11:0] e;
  logic [7:0]  md, lf = 8'h02, a, b, f;
  int          n_mismatch = 0, checks_done = 0, k;
  always #4 clk = ~clk;
  crsie_core crsie_core_inst (.clk(clk), .nrst(nrst), .ce(ce), .cmd(cmd),
    .cmd_valid(cmd_valid), .cmd_ready(cr), .mem_req(mreq), .mem_rdata(md),
    .ext_req_pend(ext_pend), .timer_req(tmr), .ext_ack(eack), .timer_ack(tack),
    .reg_addr(ra), .reg_wdata(rw), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rd));
  crsie_mem crsie_mem_inst (.clk(clk), .req(mreq), .rdata(md));
  // Outside latches: a set pulse wins over the vector fetch acknowledge
  always @(posedge clk) begin
    ext_pend <= ext_set | (ext_pend & !eack);
    tmr      <= tmr_set | (tmr & !tack);
  end
  // *****
  // Helpers
  // *****
  function automatic logic [7:0] nxt(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  // Expected {H,N,Z,C,result}; borrow is the ninth bit of the difference
  function automatic logic [11:0] alu(input logic [7:0] x, y, input logic s, ci);
    logic [8:0] r;
    logic [4:0] h;
    r = s ? {1'b0, x} - {1'b0, y} - {8'h00, ci} : {1'b0, x} + {1'b0, y} + {8'h00, ci};
    h = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
    return {h[4], r[7], r[7:0] == 8'h00, r[8], r[7:0]};
  endfunction
  task automatic chk(input logic [15:0] s, x);
    checks_done++;
    if (s !== x) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Bounded wait for the command port to go idle
  task automatic idle();
    @(negedge clk);
    for (k = 0; k < 60 && cr !== 1'b1; k++) @(negedge clk);
    if (cr !== 1'b1) begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  // One-cycle set pulse into an outside request latch
  task automatic pulse(input logic tm);
    @(posedge clk);
    tmr_set <= tm;
    ext_set <= !tm;
    @(posedge clk);
    tmr_set <= 1'b0;
    ext_set <= 1'b0;
  endtask
  task automatic wr(input logic [2:0] ad, input logic [15:0] d);
    @(posedge clk);
    ra <= ad;
    rw <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rg(input logic [2:0] ad);
    @(posedge clk);
    ra <= ad;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    v = rd;
  endtask
  task automatic op(input crsie_pkg::crsie_op_type o, input logic [15:0] d, input logic ad);
    @(posedge clk);
    cmd <= '{o, d, ad, 1'b1};
    cmd_valid <= 1'b1;
    idle();
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask
  // *****
  // Main sequence
  // *****
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rg(crsie_pkg::REG_STACK); chk(v, 16'h00ff);
    rg(crsie_pkg::REG_FLAGS); chk({v[7:5], v[3]}, 4'hf);
    wr(crsie_pkg::REG_FETCH, 16'hffff);
    rg(crsie_pkg::REG_FETCH); chk(v, 16'h07ff);
    op(crsie_pkg::OP_JUMP, 16'h0100, 1'b0);
    op(crsie_pkg::OP_NOP, 16'h0, 1'b1);
    rg(crsie_pkg::REG_FETCH); chk(v, 16'h0101);
    op(crsie_pkg::OP_LOAD_WORK, 16'h00f0, 1'b0);
    op(crsie_pkg::OP_XOR, 16'h00ff, 1'b0);
    op(crsie_pkg::OP_OR, 16'h0080, 1'b0);
    op(crsie_pkg::OP_AND, 16'h00c3, 1'b0);
    rg(crsie_pkg::REG_WORK); chk(v, 16'h0083);
    rg(crsie_pkg::REG_FLAGS); chk(v[2:1], 2'h2);
    op(crsie_pkg::OP_AND, 16'h0000, 1'b0);
    rg(crsie_pkg::REG_FLAGS); chk(v[2:1], 2'h1);
    $display("test registers done");
    for (int i = 0; i < 12; i++) begin
      lf = nxt(lf);
      a = (i < 2) ? 8'hff : lf;
      lf = nxt(lf);
      b = (i < 2) ? 8'h01 : lf;
      e = alu(a, b, i[0], i[1] & cy);
      op(crsie_pkg::OP_LOAD_WORK, {8'h0, a}, 1'b0);
      op(i[1] ? (i[0] ? crsie_pkg::OP_SBC : crsie_pkg::OP_ADC)
              : (i[0] ? crsie_pkg::OP_SUB : crsie_pkg::OP_ADD), {8'h0, b}, 1'b0);
      rg(crsie_pkg::REG_WORK); chk(v, {8'h0, e[7:0]});
      rg(crsie_pkg::REG_FLAGS); chk({v[4] & !i[0], v[2:0]}, {e[11] & !i[0], e[10:8]});
      cy = e[8];
    end
    $display("test alu done");
    op(crsie_pkg::OP_LOAD_PTR, {8'h0, b}, 1'b0);
    op(crsie_pkg::OP_MUL, 16'h0, 1'b0);
    @(negedge clk);
    for (k = 0; k < 40 && cr !== 1'b1; k++) @(negedge clk);
    chk(16'(k), 16'(crsie_pkg::MUL_CYCLES - 1));
    rg(crsie_pkg::REG_PTR); chk(v, {8'h0, 8'(({8'h0, e[7:0]} * b) >> 8)});
    rg(crsie_pkg::REG_WORK); chk(v, {8'h0, 8'({8'h0, e[7:0]} * b)});
    $display("test multiply done");
    op(crsie_pkg::OP_JUMP, 16'h0155, 1'b0);
    rg(crsie_pkg::REG_WORK); a = v[7:0];
    rg(crsie_pkg::REG_PTR); b = v[7:0];
    rg(crsie_pkg::REG_FLAGS); f = v[7:0];
    op(crsie_pkg::OP_SOFT_TRAP, 16'h0, 1'b0);
    idle();
    chk({crsie_mem_inst.mem[255], crsie_mem_inst.mem[254]}, 16'h5501);
    chk({crsie_mem_inst.mem[253], crsie_mem_inst.mem[252]}, {b, a});
    chk(crsie_mem_inst.mem[251], f);
    rg(crsie_pkg::REG_STACK); chk(v, 16'h00fa);
    rg(crsie_pkg::REG_FETCH); chk(v, 16'h0123);
    pulse(1'b0);
    op(crsie_pkg::OP_NOP, 16'h0, 1'b0);
    repeat (5) @(negedge clk);
    rg(crsie_pkg::REG_FETCH); chk(v, 16'h0123);
    op(crsie_pkg::OP_UNMASK, 16'h0, 1'b0);
    idle();
    rg(crsie_pkg::REG_FETCH); chk(v, 16'h0245);
    rg(crsie_pkg::REG_STACK); chk(v, 16'h00f5);
    rg(crsie_pkg::REG_FLAGS); chk({v[3], ext_pend}, 2'h2);
    op(crsie_pkg::OP_RETURN_TRAP, 16'h0, 1'b0);
    idle();
    rg(crsie_pkg::REG_FETCH); chk(v, 16'h0123);
    rg(crsie_pkg::REG_FLAGS); chk(v[3], 1'b0);
    $display("test interrupts done");
    op(crsie_pkg::OP_STACK_REINIT, 16'h0, 1'b0);
    rg(crsie_pkg::REG_STACK); chk(v, 16'h00ff);
    op(crsie_pkg::OP_CALL, 16'h0300, 1'b0);
    idle();
    rg(crsie_pkg::REG_FETCH); chk(v, 16'h0300);
    rg(crsie_pkg::REG_STACK); chk(v, 16'h00fd);
    op(crsie_pkg::OP_RETURN, 16'h0, 1'b0);
    idle();
    rg(crsie_pkg::REG_FETCH); chk(v, 16'h0123);
    rg(crsie_pkg::REG_STACK); chk(v, 16'h00ff);
    $display("test call done");
    wr(crsie_pkg::REG_CTRL, 16'h0);
    pulse(1'b0);
    op(crsie_pkg::OP_NOP, 16'h0, 1'b0);
    repeat (5) @(negedge clk);
    rg(crsie_pkg::REG_STACK); chk(v, 16'h00ff);
    $display("test disable done");
    // Timer request while the external one stays blocked
    pulse(1'b1);
    idle();
    rg(crsie_pkg::REG_FETCH); chk(v, 16'h0367);
    rg(crsie_pkg::REG_STACK); chk(v, 16'h00fa);
    rg(crsie_pkg::REG_STATUS); chk(v, 16'h000a);
    op(crsie_pkg::OP_STOP, 16'h0, 1'b0);
    rg(crsie_pkg::REG_FLAGS); chk(v[3], 1'b0);
    wr(crsie_pkg::REG_FLAGS, 16'h0008);
    op(crsie_pkg::OP_WAIT, 16'h0, 1'b0);
    rg(crsie_pkg::REG_FLAGS); chk(v[3], 1'b0);
    $display("test timer done");
    // Mid-run reset keeps the result flags, then a frozen write is lost
    wr(crsie_pkg::REG_FLAGS, 16'h0015);
    @(posedge clk) nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rg(crsie_pkg::REG_FLAGS); chk(v, 16'h00fd);
    rg(crsie_pkg::REG_STACK); chk(v, 16'h00ff);
    rg(crsie_pkg::REG_CTRL); chk(v, 16'h0001);
    @(posedge clk) ce <= 1'b0;
    wr(crsie_pkg::REG_WORK, 16'h0055);
    ce <= 1'b1;
    rg(crsie_pkg::REG_WORK); chk(v, 16'h0000);
    $display("test reset done");
    wrap_up();
  end
endmodule
